// file: inc/rbs_pkg.sv
// Constants, register map and carrier types for the recipe batch sequencer.
// Assumes a single 10 MHz clock and a word-addressed plain register port.
package rbs_pkg;
  localparam int N_RCP = 30;
  localparam int N_LINE = 30;
  localparam int N_ACT = 24;
  localparam int N_IO = 34;
  localparam logic [4:0] NUM_RCP = 5'h1e;
  localparam logic [4:0] NUM_LINE = 5'h1e;
  localparam logic [4:0] NUM_ACT = 5'h18;
  localparam logic [5:0] NUM_IO = 6'h22;
  localparam logic [5:0] NO_IO = 6'h3f;
  localparam logic [4:0] LAST_LINE = 5'h1d;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_REPEAT = 8'h01;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_CLR = 8'h03;
  localparam logic [7:0] A_CAP = 8'h04;
  localparam logic [7:0] A_RES = 8'h05;
  localparam logic [7:0] A_OSEL = 8'h06;
  localparam logic [7:0] A_LPTR = 8'h08;
  localparam logic [7:0] A_LACT = 8'h09;
  localparam logic [7:0] A_LSETP = 8'h0a;
  localparam logic [7:0] A_APTR = 8'h0b;
  localparam logic [7:0] A_ADEF = 8'h0c;
  localparam int CFG_CHK = 0;
  localparam int CFG_RSEL = 8;
  localparam int OS_HALT = 8;
  localparam int OS_ALM = 16;
  localparam int LP_LINE = 8;
  localparam int AD_OUT = 8;
  localparam int AD_IN = 16;
  localparam int ST_HALT = 1;
  localparam int ST_ALM = 2;
  localparam int ST_REJ = 3;
  localparam int ST_CAUSE = 4;
  localparam int ST_LINE = 8;
  localparam int ST_BATCH = 16;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [3:0] T_NONE = 4'h0;
  localparam logic [3:0] T_WIN = 4'h1;
  localparam logic [3:0] T_WOUT = 4'h2;
  localparam logic [3:0] T_DUMP = 4'h3;
  localparam logic [3:0] T_FILL = 4'h4;
  localparam logic [3:0] T_TMR = 4'h5;
  localparam logic [3:0] T_TOUT = 4'h6;
  localparam logic [3:0] T_LSET = 4'h7;
  localparam logic [3:0] T_LCLR = 4'h8;
  localparam logic [3:0] T_MAN = 4'h9;
  localparam logic [3:0] T_PULSE = 4'ha;
  localparam logic [2:0] C_CAP = 3'h1;
  localparam logic [2:0] C_MAT = 3'h2;
  localparam logic [2:0] C_CHKCAP = 3'h3;
  localparam logic [2:0] C_CHKMAT = 3'h4;
  // Timer setpoints count tenths of a second
  localparam logic [31:0] TMR_MAX = 32'h0098_9676;
  localparam logic [31:0] WOUT_STEPS = 32'h0000_0014;
  localparam int TICK_NS = 100_000_000;
  localparam int MCLK_NS = 100;
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_FETCH, S_WEIGH, S_TIMER,
    S_TOUT, S_WAITIN, S_MANUAL, S_HALT, S_ALARM
  } rbs_fsm_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } rbs_bus_t;
  typedef struct packed {
    logic [N_RCP-1:0][N_LINE-1:0][4:0] lsel;
    logic [N_RCP-1:0][N_LINE-1:0][31:0] setp;
    logic [N_ACT-1:0][3:0] atype;
    logic [N_ACT-1:0][5:0] aout;
    logic [N_ACT-1:0][5:0] ain;
    logic chk_en;
    logic [4:0] rsel;
    logic [15:0] rep;
    logic [31:0] cap;
    logic [15:0] res;
    logic [5:0] os_run;
    logic [5:0] os_halt;
    logic [5:0] os_alm;
    logic [4:0] prcp;
    logic [4:0] pline;
    logic [4:0] pact;
    rbs_fsm_t st;
    rbs_fsm_t resume;
    logic [4:0] rrcp;
    logic [4:0] line;
    logic [15:0] batch;
    logic signed [31:0] sim;
    logic signed [31:0] tare;
    logic [23:0] tmr;
    logic [19:0] tcnt;
    logic running;
    logic halted;
    logic alarm;
    logic reject;
    logic [2:0] cause;
    logic [33:0] latch;
    logic [33:0] dout;
    logic [31:0] rdata;
    logic signed [31:0] disp;
  } rbs_state_t;
endpackage : rbs_pkg

// file: hw/rbs_seq.sv
// Recipe batch sequencer: recipe store, activity table, line stepping.
// Assumes keys and inputs synchronous to i_mclk, keys as one-cycle pulses.
//
// What this block does
// - Store 30 recipes of 30 lines
// - Table of up to 24 typed activities
// - Run lines in ascending order
// - Repeat whole recipe configured times
// - Skip setpoint activity whose setpoint is zero
// - Only six activity types use setpoints
// - Timer setpoint: tenths, 0.0 to 999999.0
// - Running indication held for whole run
// - Status indications on configured outputs
// - Reject edits to the running recipe
// - Recipe check simulates before real work
// - Failed simulation raises batching alarm
// - Manual halts until operator restart
// - Timer waits setpoint, no output
// - Timer output on for setpoint only
// - Latch set holds output, clear drops
// - Weigh-out presented weight never positive
// - Selection fields address 34 inputs, outputs
// - Weigh-in capacity check else alarm, release
// - Weigh-out needs setpoint plus twenty steps
`timescale 1ns/100ps
module rbs_seq #(
  parameter int unsigned P_TICK = rbs_pkg::TICK_NS / rbs_pkg::MCLK_NS
) (
  input wire logic i_mclk, // 10 MHz clock
  input wire logic i_rstn, // async reset, low
  input wire rbs_pkg::rbs_bus_t i_bus, // register port
  output logic [31:0] o_rdata, // read data, cycle after read
  input wire logic i_start_key, // start / resume pulse
  input wire logic i_stop_key, // stop pulse
  input wire logic i_alarm_reset, // alarm reset pulse
  input wire logic [33:0] i_din, // digital inputs
  input wire logic signed [31:0] i_gross, // gross weight
  output logic [33:0] o_dout, // digital outputs
  output logic signed [31:0] o_disp, // presented weight
  output logic o_running, // batch in progress
  output logic o_halted, // batch stopped
  output logic o_alarm // batch alarm
);

  localparam logic [19:0] TICK_LAST = 20'(P_TICK - 1);

  rbs_pkg::rbs_state_t r;
  rbs_pkg::rbs_state_t n;
  logic tick;
  logic act_on;
  logic cur_ok;
  logic [4:0] cur_a;
  logic [3:0] cur_ty;
  logic [5:0] cur_ao;
  logic [5:0] cur_ai;
  logic signed [31:0] cur_sp;
  logic signed [31:0] wout_lim;
  logic cap_hit;
  logic lp_ok;
  logic [33:0] dnext;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic uses_sp(input logic [3:0] t);
    return t == rbs_pkg::T_WIN || t == rbs_pkg::T_WOUT || t == rbs_pkg::T_TMR ||
           t == rbs_pkg::T_TOUT || t == rbs_pkg::T_MAN || t == rbs_pkg::T_PULSE;
  endfunction : uses_sp

  function automatic rbs_pkg::rbs_state_t adv(input rbs_pkg::rbs_state_t s,
                                              input logic signed [31:0] g);
    rbs_pkg::rbs_state_t o;
    o = s;
    o.st = rbs_pkg::S_FETCH;
    if (s.line != rbs_pkg::LAST_LINE) begin
      o.line = s.line + 5'h1;
    end else if (s.batch + 16'h1 >= s.rep) begin
      o.st = rbs_pkg::S_IDLE;
      o.running = 1'b0;
      o.halted = 1'b0;
      o.line = 5'h0;
    end else begin
      o.batch = s.batch + 16'h1;
      o.line = 5'h0;
      if (s.chk_en) begin
        o.st = rbs_pkg::S_CHECK;
        o.sim = g;
      end
    end
    return o;
  endfunction : adv

  function automatic rbs_pkg::rbs_state_t alm(input rbs_pkg::rbs_state_t s,
                                              input logic [2:0] c,
                                              input rbs_pkg::rbs_fsm_t rs);
    rbs_pkg::rbs_state_t o;
    o = s;
    o.st = rbs_pkg::S_ALARM;
    o.alarm = 1'b1;
    o.halted = 1'b1;
    o.cause = c;
    o.resume = rs;
    return o;
  endfunction : alm

  //////////////////////////////////////////////////////////////////////////
  // Decode of the line being executed
  assign cur_a = r.lsel[r.rrcp][r.line];
  assign cur_ok = cur_a != 5'h0 && cur_a <= rbs_pkg::NUM_ACT;
  assign cur_ty = cur_ok ? r.atype[cur_a - 5'h1] : rbs_pkg::T_NONE;
  assign cur_ao = cur_ok ? r.aout[cur_a - 5'h1] : rbs_pkg::NO_IO;
  assign cur_ai = cur_ok ? r.ain[cur_a - 5'h1] : rbs_pkg::NO_IO;
  assign cur_sp = $signed(r.setp[r.rrcp][r.line]);
  assign wout_lim = cur_sp + $signed(32'({16'h0, r.res} * rbs_pkg::WOUT_STEPS));
  assign cap_hit = i_gross + cur_sp >= $signed(r.cap);
  assign lp_ok = r.prcp < rbs_pkg::NUM_RCP && r.pline < rbs_pkg::NUM_LINE;
  assign tick = r.tcnt == TICK_LAST;
  assign act_on = r.st == rbs_pkg::S_WEIGH || r.st == rbs_pkg::S_TOUT ||
                  r.st == rbs_pkg::S_WAITIN;

  // Output image is one cycle behind the state to keep outputs on flops
  for (genvar i = 0; i < rbs_pkg::N_IO; i++) begin : g_dout
    localparam logic [5:0] IDX = 6'(i);
    assign dnext[i] = r.latch[i] | (act_on && cur_ao == IDX) |
                      (r.running && r.os_run == IDX) |
                      (r.halted && r.os_halt == IDX) |
                      (r.alarm && r.os_alm == IDX);
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic signed [31:0] e;
    logic [31:0] t;
    e = i_gross - r.tare;
    t = 32'h0;
    n = r;
    n.tcnt = tick ? 20'h0 : r.tcnt + 20'h1;
    n.rdata = 32'h0;
    n.dout = dnext;
    n.disp = i_gross;
    if (i_bus.we) begin
      case (i_bus.addr)
        rbs_pkg::A_CFG: begin
          n.chk_en = i_bus.wdata[rbs_pkg::CFG_CHK];
          n.rsel = i_bus.wdata[rbs_pkg::CFG_RSEL +: 5];
        end
        rbs_pkg::A_REPEAT: n.rep = i_bus.wdata[15:0];
        rbs_pkg::A_CLR: begin
          if (i_bus.wdata[rbs_pkg::ST_REJ]) begin
            n.reject = 1'b0;
          end
        end
        rbs_pkg::A_CAP: n.cap = i_bus.wdata;
        rbs_pkg::A_RES: n.res = i_bus.wdata[15:0];
        rbs_pkg::A_OSEL: begin
          n.os_run = i_bus.wdata[5:0];
          n.os_halt = i_bus.wdata[rbs_pkg::OS_HALT +: 6];
          n.os_alm = i_bus.wdata[rbs_pkg::OS_ALM +: 6];
        end
        rbs_pkg::A_LPTR: begin
          n.prcp = i_bus.wdata[4:0];
          n.pline = i_bus.wdata[rbs_pkg::LP_LINE +: 5];
        end
        rbs_pkg::A_LACT, rbs_pkg::A_LSETP: begin
          if (r.running && r.prcp == r.rrcp) begin
            n.reject = 1'b1;
          end else if (lp_ok && i_bus.addr == rbs_pkg::A_LACT) begin
            n.lsel[r.prcp][r.pline] = i_bus.wdata[4:0];
          end else if (lp_ok) begin
            n.setp[r.prcp][r.pline] = i_bus.wdata;
          end
        end
        rbs_pkg::A_APTR: n.pact = i_bus.wdata[4:0];
        rbs_pkg::A_ADEF: begin
          if (r.pact < rbs_pkg::NUM_ACT) begin
            n.atype[r.pact] = i_bus.wdata[3:0];
            n.aout[r.pact] = i_bus.wdata[rbs_pkg::AD_OUT +: 6];
            n.ain[r.pact] = i_bus.wdata[rbs_pkg::AD_IN +: 6];
          end
        end
        default: ;
      endcase
    end
    if (i_bus.re) begin
      case (i_bus.addr)
        rbs_pkg::A_CFG: begin
          n.rdata[rbs_pkg::CFG_CHK] = r.chk_en;
          n.rdata[rbs_pkg::CFG_RSEL +: 5] = r.rsel;
        end
        rbs_pkg::A_REPEAT: n.rdata = {16'h0, r.rep};
        rbs_pkg::A_STATUS: begin
          n.rdata[0] = r.running;
          n.rdata[rbs_pkg::ST_HALT] = r.halted;
          n.rdata[rbs_pkg::ST_ALM] = r.alarm;
          n.rdata[rbs_pkg::ST_REJ] = r.reject;
          n.rdata[rbs_pkg::ST_CAUSE +: 3] = r.cause;
          n.rdata[rbs_pkg::ST_LINE +: 5] = r.line;
          n.rdata[rbs_pkg::ST_BATCH +: 16] = r.batch;
        end
        rbs_pkg::A_CAP: n.rdata = r.cap;
        rbs_pkg::A_RES: n.rdata = {16'h0, r.res};
        rbs_pkg::A_OSEL: begin
          n.rdata[5:0] = r.os_run;
          n.rdata[rbs_pkg::OS_HALT +: 6] = r.os_halt;
          n.rdata[rbs_pkg::OS_ALM +: 6] = r.os_alm;
        end
        rbs_pkg::A_LPTR: begin
          n.rdata[4:0] = r.prcp;
          n.rdata[rbs_pkg::LP_LINE +: 5] = r.pline;
        end
        rbs_pkg::A_LACT: begin
          if (lp_ok) begin
            n.rdata[4:0] = r.lsel[r.prcp][r.pline];
          end
        end
        rbs_pkg::A_LSETP: begin
          if (lp_ok) begin
            n.rdata = r.setp[r.prcp][r.pline];
          end
        end
        rbs_pkg::A_APTR: n.rdata[4:0] = r.pact;
        rbs_pkg::A_ADEF: begin
          if (r.pact < rbs_pkg::NUM_ACT) begin
            n.rdata[3:0] = r.atype[r.pact];
            n.rdata[rbs_pkg::AD_OUT +: 6] = r.aout[r.pact];
            n.rdata[rbs_pkg::AD_IN +: 6] = r.ain[r.pact];
          end
        end
        default: ;
      endcase
    end
    ////////////////////////////////////////////////////////////////////////
    case (r.st)
      rbs_pkg::S_IDLE: begin
        if (i_start_key) begin
          n.rrcp = r.rsel;
          n.line = 5'h0;
          n.batch = 16'h0;
          n.running = 1'b1;
          n.halted = 1'b0;
          n.sim = i_gross;
          n.st = r.chk_en ? rbs_pkg::S_CHECK : rbs_pkg::S_FETCH;
        end
      end
      rbs_pkg::S_CHECK: begin
        // Simulated weight walks the recipe; no activity output is driven, latched outputs keep their state
        if (cur_ty == rbs_pkg::T_WIN && cur_sp != 32'h0) begin
          if (r.sim + cur_sp >= $signed(r.cap)) begin
            n = alm(n, rbs_pkg::C_CHKCAP, rbs_pkg::S_CHECK);
          end else begin
            n.sim = r.sim + cur_sp;
          end
        end else if (cur_ty == rbs_pkg::T_WOUT && cur_sp != 32'h0) begin
          if (r.sim <= wout_lim) begin
            n = alm(n, rbs_pkg::C_CHKMAT, rbs_pkg::S_CHECK);
          end else begin
            n.sim = r.sim - cur_sp;
          end
        end
        if (n.st == rbs_pkg::S_CHECK) begin
          if (r.line == rbs_pkg::LAST_LINE) begin
            n.line = 5'h0;
            n.st = rbs_pkg::S_FETCH;
          end else begin
            n.line = r.line + 5'h1;
          end
        end
      end
      rbs_pkg::S_FETCH: begin
        if (cur_ty == rbs_pkg::T_NONE || (uses_sp(cur_ty) && cur_sp == 32'h0)) begin
          n = adv(n, i_gross);
        end else begin
          case (cur_ty)
            rbs_pkg::T_WIN: begin
              if (cap_hit) begin
                n = alm(n, rbs_pkg::C_CAP, rbs_pkg::S_FETCH);
                n.latch = '0;
              end else begin
                n.tare = i_gross;
                n.st = rbs_pkg::S_WEIGH;
              end
            end
            rbs_pkg::T_WOUT: begin
              if (i_gross <= wout_lim) begin
                n = alm(n, rbs_pkg::C_MAT, rbs_pkg::S_FETCH);
              end else begin
                n.tare = i_gross;
                n.st = rbs_pkg::S_WEIGH;
              end
            end
            rbs_pkg::T_TMR, rbs_pkg::T_TOUT: begin
              t = ($unsigned(cur_sp) > rbs_pkg::TMR_MAX) ? rbs_pkg::TMR_MAX
                                                         : $unsigned(cur_sp);
              n.tmr = t[23:0];
              n.tcnt = 20'h0;
              n.st = (cur_ty == rbs_pkg::T_TMR) ? rbs_pkg::S_TIMER : rbs_pkg::S_TOUT;
            end
            rbs_pkg::T_LSET, rbs_pkg::T_LCLR: begin
              if (cur_ao < rbs_pkg::NUM_IO) begin
                n.latch[cur_ao] = cur_ty == rbs_pkg::T_LSET;
              end
              n = adv(n, i_gross);
            end
            rbs_pkg::T_MAN: begin
              n.st = rbs_pkg::S_MANUAL;
              n.halted = 1'b1;
            end
            default: n.st = rbs_pkg::S_WAITIN;
          endcase
        end
      end
      rbs_pkg::S_WEIGH: begin
        if (cur_ty == rbs_pkg::T_WOUT) begin
          n.disp = (e > 32'sh0) ? -e : e;
          if (-e >= cur_sp) begin
            n = adv(n, i_gross);
          end
        end else if (e >= cur_sp) begin
          n = adv(n, i_gross);
        end
      end
      rbs_pkg::S_TIMER, rbs_pkg::S_TOUT: begin
        if (tick) begin
          if (r.tmr <= 24'h1) begin
            n = adv(n, i_gross);
          end else begin
            n.tmr = r.tmr - 24'h1;
          end
        end
      end
      rbs_pkg::S_WAITIN: begin
        // Dump, fill and pulse lines end on their completion input
        if (cur_ai >= rbs_pkg::NUM_IO || i_din[cur_ai]) begin
          n = adv(n, i_gross);
        end
      end
      rbs_pkg::S_MANUAL: begin
        if (i_start_key) begin
          n = adv(n, i_gross);
          n.halted = 1'b0;
        end
      end
      rbs_pkg::S_HALT: begin
        if (i_start_key) begin
          n.st = r.resume;
          n.halted = 1'b0;
          if (r.resume == rbs_pkg::S_CHECK) begin
            n.line = 5'h0;
            n.sim = i_gross;
          end
        end
      end
      rbs_pkg::S_ALARM: begin
        if (i_alarm_reset) begin
          n.alarm = 1'b0;
          n.cause = 3'h0;
          n.st = rbs_pkg::S_HALT;
        end
      end
      default: n.st = rbs_pkg::S_IDLE;
    endcase
    // Stop parks the state it would have entered; resume re-enters it, but a parked check restarts at line 0
    if (i_stop_key && n.st inside {rbs_pkg::S_CHECK, rbs_pkg::S_FETCH, rbs_pkg::S_WEIGH,
                                   rbs_pkg::S_TIMER, rbs_pkg::S_TOUT, rbs_pkg::S_WAITIN}) begin
      n.resume = n.st;
      n.st = rbs_pkg::S_HALT;
      n.halted = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_rdata = r.rdata;
  assign o_dout = r.dout;
  assign o_disp = r.disp;
  assign o_running = r.running;
  assign o_halted = r.halted;
  assign o_alarm = r.alarm;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_fetch_go;
    r.st == rbs_pkg::S_FETCH && !i_stop_key;
  endsequence

  a_idle_norun: assert property (r.st == rbs_pkg::S_IDLE |-> !o_running)
    else $error("running flag set while idle");
  a_start_run: assert property ((r.st == rbs_pkg::S_IDLE && i_start_key) |=> o_running)
    else $error("start did not raise running");
  a_alarm_halt: assert property (o_alarm |-> o_halted)
    else $error("alarm without halted");
  a_alarm_hold: assert property ((r.st == rbs_pkg::S_ALARM && !i_alarm_reset)
                                 |=> r.st == rbs_pkg::S_ALARM && o_alarm)
    else $error("alarm left without reset");
  a_line_step: assert property ((r.running && $past(r.running) && $changed(r.line))
                                |-> (r.line == $past(r.line) + 5'h1 || r.line == 5'h0))
    else $error("line out of order");
  a_skip_zero: assert property ((s_fetch_go ##0 (uses_sp(cur_ty) && cur_sp == 32'h0))
                                |=> (r.line != $past(r.line) || !r.running))
    else $error("zero setpoint line not skipped");
  a_cap_alarm: assert property ((s_fetch_go ##0 (cur_ty == rbs_pkg::T_WIN &&
                                 cur_sp != 32'h0 && cap_hit))
                                |=> (o_alarm && r.latch == '0))
    else $error("capacity alarm missing");
  a_wout_alarm: assert property ((s_fetch_go ##0 (cur_ty == rbs_pkg::T_WOUT &&
                                  cur_sp != 32'h0 && i_gross <= wout_lim)) |=> o_alarm)
    else $error("material alarm missing");
  a_chk_first: assert property ((r.st == rbs_pkg::S_IDLE && i_start_key && r.chk_en)
                                |=> r.st == rbs_pkg::S_CHECK)
    else $error("recipe check not first");
  a_chk_alarm: assert property ((r.st == rbs_pkg::S_CHECK && cur_ty == rbs_pkg::T_WIN &&
                                 cur_sp != 32'h0 && r.sim + cur_sp >= $signed(r.cap))
                                |=> o_alarm)
    else $error("check failure without alarm");
  a_timer_hold: assert property ((r.st == rbs_pkg::S_TIMER && !tick && !i_stop_key)
                                 |=> r.st == rbs_pkg::S_TIMER)
    else $error("timer ended without tick");
  a_tout_drive: assert property ((r.st == rbs_pkg::S_TOUT && cur_ao < rbs_pkg::NUM_IO)
                                 |=> o_dout[$past(cur_ao)])
    else $error("timer output not driven");
  a_latch_set: assert property ((s_fetch_go ##0 (cur_ty == rbs_pkg::T_LSET &&
                                 cur_ao < rbs_pkg::NUM_IO))
                                |=> r.latch[$past(cur_ao)] ##1 o_dout[$past(cur_ao, 2)])
    else $error("latch output not set");
  a_edit_rej: assert property ((i_bus.we && i_bus.addr == rbs_pkg::A_LSETP && r.running &&
                                r.prcp == r.rrcp) |=> (r.reject && $stable(r.setp)))
    else $error("edit of running recipe accepted");
  a_manual_wait: assert property ((r.st == rbs_pkg::S_MANUAL && !i_start_key)
                                  |=> (r.st == rbs_pkg::S_MANUAL && o_halted))
    else $error("manual line left without start");

endmodule : rbs_seq

// file: verif/rbs_scale.sv
// Far-side model: weighing scale and process inputs.
// Assumes output 2 opens the feed valve; only input 3 follows output 3, other inputs stay low.
`timescale 1ns/100ps
module rbs_scale (
  input wire logic i_mclk, // clock
  input wire logic [33:0] i_dout, // process outputs
  output logic signed [31:0] o_gross, // gross weight
  output logic [33:0] o_din // digital inputs
);
  logic signed [31:0] gross_q = 32'sh0;
  // Material only arrives while the valve is open, so a released output stops growth
  always @(posedge i_mclk) if (i_dout[2]) gross_q <= gross_q + 32'sh4;
  assign o_gross = gross_q;
  assign o_din = {30'h0, i_dout[3], 3'h0};
endmodule : rbs_scale

// file: verif/rbs_seq_test.sv
// Bench for the recipe batch sequencer: register tasks and batch runs.
// Assumes the scale model on the far side and a 4-cycle timer tick.
`timescale 1ns/100ps
module rbs_seq_test;
  logic clk, rstn, st, sp, ar, run, hlt, alm;
  rbs_pkg::rbs_bus_t bus;
  logic [31:0] rd, o_rdata;
  logic [33:0] dout, din;
  logic signed [31:0] gross, disp;
  int failures, checks, cyc, n;
  rbs_seq #(.P_TICK(4)) u_rbs_seq (.i_mclk(clk), .i_rstn(rstn), .i_bus(bus),
    .o_rdata(o_rdata), .i_start_key(st), .i_stop_key(sp), .i_alarm_reset(ar),
    .i_din(din), .i_gross(gross), .o_dout(dout), .o_disp(disp), .o_running(run),
    .o_halted(hlt), .o_alarm(alm));
  rbs_scale u_rbs_scale (.i_mclk(clk), .i_dout(dout), .o_gross(gross), .o_din(din));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, we: w, re: !w};
    @(posedge clk);
    bus <= '0;
    #1 rd = o_rdata;
  endtask : acc
  task automatic key(input int k);
    @(posedge clk);
    {st, sp, ar} <= 3'b100 >> k;
    @(posedge clk);
    {st, sp, ar} <= 3'h0;
    #1;
  endtask : key
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 300; i++) begin
      acc(rbs_pkg::A_STATUS, 32'h0, 1'b0);
      if ((rd & m) === v) break;
    end
  endtask : poll
  task automatic line(input logic [4:0] r, input logic [4:0] l, input logic [4:0] a,
    input logic [31:0] s);
    acc(rbs_pkg::A_LPTR, {19'h0, l, 3'h0, r}, 1'b1);
    acc(rbs_pkg::A_LACT, {27'h0, a}, 1'b1);
    acc(rbs_pkg::A_LSETP, s, 1'b1);
  endtask : line
  task automatic act(input logic [4:0] k, input logic [3:0] t, input logic [5:0] o);
    acc(rbs_pkg::A_APTR, {27'h0, k}, 1'b1);
    acc(rbs_pkg::A_ADEF, {10'h0, 6'h3f, 2'h0, o, 4'h0, t}, 1'b1);
  endtask : act
  task automatic end_sim();
    $display("Checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    bus = '0;
    {st, sp, ar} = 3'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    acc(rbs_pkg::A_STATUS, 32'h0, 1'b0);
    chk("status", 32'h0, rd);
    acc(8'h07, 32'h5a, 1'b1);
    acc(8'h07, 32'h0, 1'b0);
    chk("unmapped", 32'h0, rd);
    key(1);
    chk("idle stop", 32'h0, {31'h0, hlt});
    $display("reset test done");
    // Status on outputs 30..32, activities 1..4 at table slots 0..3
    acc(rbs_pkg::A_CAP, 32'h3e8, 1'b1);
    acc(rbs_pkg::A_OSEL, 32'h0020_1f1e, 1'b1);
    act(5'h0, rbs_pkg::T_TOUT, 6'h05);
    act(5'h1, rbs_pkg::T_LSET, 6'h07);
    act(5'h2, rbs_pkg::T_WIN, 6'h02);
    act(5'h3, rbs_pkg::T_MAN, 6'h3f);
    line(5'h0, 5'h0, 5'h2, 32'h0);
    line(5'h0, 5'h1, 5'h1, 32'h2);
    line(5'h0, 5'h2, 5'h1, 32'h0);
    line(5'h0, 5'h3, 5'h4, 32'h1);
    key(0);
    chk("running", 32'h1, {31'h0, run});
    for (int i = 0; i < 60 && !dout[5]; i++) @(posedge clk) #1;
    n = 0;
    while (dout[5] && n < 60) begin
      @(posedge clk) #1;
      n++;
    end
    chk("tout len", 32'h8, n);
    poll(32'h1f00, 32'h0300);
    acc(rbs_pkg::A_STATUS, 32'h0, 1'b0);
    chk("manual", 32'h0000_0303, rd & 32'h1f03);
    chk("outputs", 32'h1c, {25'h0, dout[33:30], dout[7:5]});
    line(5'h0, 5'h5, 5'h1, 32'h1);
    acc(rbs_pkg::A_STATUS, 32'h0, 1'b0);
    chk("reject", 32'h8, rd & 32'h8);
    acc(rbs_pkg::A_CLR, 32'h8, 1'b1);
    line(5'h1, 5'h0, 5'h3, 32'h28);
    acc(rbs_pkg::A_LSETP, 32'h0, 1'b0);
    chk("other recipe", 32'h28, rd);
    key(0);
    poll(32'h1, 32'h0);
    chk("run end", 32'h4, {24'h0, rd[3:0], dout[30], dout[7:5]});
    $display("sequence test done");
    acc(rbs_pkg::A_CAP, 32'ha, 1'b1);
    acc(rbs_pkg::A_CFG, 32'h100, 1'b1);
    key(0);
    poll(32'h4, 32'h4);
    chk("cap alarm", 32'h17, rd & 32'h7f);
    chk("alarm outs", 32'h1c, {27'h0, dout[32:30], dout[7], dout[2]});
    key(0);
    chk("no restart", 32'h1, {31'h0, alm});
    key(2);
    acc(rbs_pkg::A_CAP, 32'h3e8, 1'b1);
    key(0);
    poll(32'h1, 32'h0);
    chk("weigh in", 32'h1, {31'h0, gross >= 32'sh28});
    acc(rbs_pkg::A_CFG, 32'h101, 1'b1);
    acc(rbs_pkg::A_REPEAT, 32'h2, 1'b1);
    n = gross;
    key(0);
    poll(32'h1, 32'h0);
    chk("repeats", 32'h1, {31'h0, gross >= n + 80});
    // Weigh-out short of material, then the same slot as a plain timer that is stopped
    act(5'h4, rbs_pkg::T_WOUT, 6'h3f);
    line(5'h2, 5'h0, 5'h5, 32'h3);
    acc(rbs_pkg::A_RES, 32'h10, 1'b1);
    acc(rbs_pkg::A_CFG, 32'h200, 1'b1);
    key(0);
    poll(32'h4, 32'h4);
    chk("material alarm", 32'h2, {29'h0, rd[6:4]});
    key(2);
    act(5'h4, rbs_pkg::T_TMR, 6'h05);
    key(0);
    key(1);
    chk("timer stop", 32'h2, {30'h0, hlt, dout[5]});
    key(0);
    poll(32'h1, 32'h0);
    chk("disp", gross, disp);
    acc(rbs_pkg::A_CFG, 32'h101, 1'b1);
    acc(rbs_pkg::A_CAP, 32'h64, 1'b1);
    n = gross;
    key(0);
    poll(32'h4, 32'h4);
    chk("check alarm", 32'h3, {29'h0, rd[6:4]});
    chk("no real work", n, gross);
    $display("alarm test done");
    end_sim();
  end
endmodule : rbs_seq_test
